// ### src/nce_core.sv
// Purpose: Fetch, decode and execute for the 4-bit processor core.
// Assumes: Program memory answers bus_in in the same cycle as the fetch phase.
// Notes: Pages roll over naturally because jumps use the incremented counter.
// Notes on behaviour
// RULE_01 - All-zero word changes nothing, just advances.
// RULE_02 - Load immediate puts operand into accumulator.
// RULE_03 - Load from index copies register into accumulator.
// RULE_04 - Swap exchanges accumulator and register via buffer.
// RULE_05 - Add with carry; carry set above fifteen.
// RULE_06 - Subtract with borrow; carry zero on borrow.
// RULE_07 - Increment register, wrap to zero, carry kept.
// RULE_08 - Return pops stack and loads operand.
// RULE_09 - Indirect jump loads pair into low eight.
// RULE_10 - Indirect jump at page end uses next page.
// RULE_11 - Send pair on bus in slots two, three.
// RULE_12 - Chips decode address as chip, register, character.
// RULE_13 - Chips hold sent address until next send.
// RULE_14 - Conditional jump fetches second word as target.
// RULE_15 - Condition bits: invert, zero, carry, test low.
// RULE_16 - Jump is OR of tests; invert flips test.
// RULE_17 - Conditional jump at words 254-255 uses next page.
// RULE_18 - Increment and jump unless result is zero.
// RULE_19 - Increment-skip at words 254-255 uses next page.
// RULE_20 - Fetch immediate loads second word into pair.
// RULE_21 - Words arrive as upper nibble then operand nibble.
// RULE_22 - Three return registers besides program counter.
// RULE_23 - Page is 256 words; jumps replace low eight.
// RULE_24 - Sixteen index registers; pairs are 2n, 2n+1.
// RULE_25 - Counter advances one per fetched word.
`timescale 1ns/10ps
module nce_core #(
  parameter int STACK_DEPTH = nce_pkg::NCE_STACK_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] bus_in,
  input wire logic test_pin,
  output logic [nce_pkg::NCE_PC_W-1:0] prog_addr,
  output logic fetch_upper,
  output logic fetch_lower,
  output nce_pkg::nce_bus_t bus_o,
  output logic [3:0] acc_o,
  output logic carry_link_o
);
  import nce_pkg::*;

  initial
  begin
    if (STACK_DEPTH < 1)
    begin
      $error("STACK_DEPTH must be at least one.");
    end
  end

  nce_state_t state_r;
  nce_state_t state_nxt;
  logic [3:0] opcode_upper_nibble_r;
  logic [3:0] operand_nibble_r;
  logic [3:0] word2_hi_r;
  logic [3:0] acc_r;
  logic [3:0] acc_nxt;
  logic carry_link_r;
  logic carry_link_nxt;
  logic [3:0] accumulator_buffer_r;
  logic [3:0] index_r [16];
  logic [NCE_PC_W-1:0] pc_r;
  logic [NCE_PC_W-1:0] pc_nxt;
  logic [NCE_PC_W-1:0] stack_r [STACK_DEPTH];
  nce_bus_t bus_r;
  nce_bus_t bus_nxt;
  logic test_s;
  logic fetch_upper_r;
  logic fetch_lower_r;

  // The test pin is asynchronous to the core clock.
  nce_sync2 u_test_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(test_pin),
    .sync_out(test_s)
  );

  wire st_opr = (state_r == NCE_ST_OPR);
  wire st_opa = (state_r == NCE_ST_OPA);
  wire st_exe = (state_r == NCE_ST_EXE);
  wire st_opr2 = (state_r == NCE_ST_OPR2);
  wire st_opa2 = (state_r == NCE_ST_OPA2);
  wire st_x2 = (state_r == NCE_ST_X2);

  wire [3:0] opcode_upper_nibble = opcode_upper_nibble_r;
  wire [3:0] operand_nibble = operand_nibble_r;
  wire odd_opa = operand_nibble[0];
  wire is_nop = (opcode_upper_nibble == NCE_OP_NOP);
  wire is_jcn = (opcode_upper_nibble == NCE_OP_JCN);
  wire is_src = (opcode_upper_nibble == NCE_OP_PAIR_SEND) && odd_opa;
  wire is_fim = (opcode_upper_nibble == NCE_OP_PAIR_SEND) && !odd_opa;
  wire is_jin = (opcode_upper_nibble == NCE_OP_PAIR_JUMP) && odd_opa;
  wire is_inc = (opcode_upper_nibble == NCE_OP_INC);
  wire is_isz = (opcode_upper_nibble == NCE_OP_ISZ);
  wire is_add = (opcode_upper_nibble == NCE_OP_ADD);
  wire is_sub = (opcode_upper_nibble == NCE_OP_SUB);
  wire is_ld = (opcode_upper_nibble == NCE_OP_LD);
  wire is_xch = (opcode_upper_nibble == NCE_OP_XCH);
  wire is_ret = (opcode_upper_nibble == NCE_OP_RET);
  wire is_ldm = (opcode_upper_nibble == NCE_OP_LDM);
  wire two_word = is_jcn || is_fim || is_isz;

  // Pair select n names registers 2n and 2n+1.
  wire [3:0] even_idx = {operand_nibble[3:1], 1'b0}; // RULE_24
  wire [3:0] odd_idx = {operand_nibble[3:1], 1'b1}; // RULE_24
  wire [3:0] sel_val = index_r[operand_nibble];
  wire [3:0] even_val = index_r[even_idx];
  wire [3:0] odd_val = index_r[odd_idx];

  wire [4:0] sum_add = {1'b0, acc_r} + {1'b0, sel_val} + {4'h0, carry_link_r}; // RULE_05
  wire [4:0] sum_sub = {1'b0, acc_r} + {1'b0, ~sel_val} + {4'h0, ~carry_link_r}; // RULE_06
  wire [3:0] inc_val = sel_val + 4'h1; // RULE_07

  // Only the test term follows the invert bit, as the jump equation does.
  wire test_term = operand_nibble[3] ? test_s : !test_s; // RULE_16
  wire cond_true = ((acc_r == 4'h0) && operand_nibble[2]) || (carry_link_r && operand_nibble[1]) || (test_term && operand_nibble[0]); // RULE_15
  wire jump2 = (is_jcn && cond_true) || (is_isz && (inc_val != 4'h0)); // RULE_14

  wire [NCE_PC_W-1:0] pc_p1 = pc_r + 12'h001;
  wire [7:0] word2 = {word2_hi_r, bus_in};

  // Targets take the page of the counter after the last word, so page-end words roll over.
  wire [NCE_PC_W-1:0] jin_target = {pc_r[11:8], even_val, odd_val}; // RULE_10
  wire [NCE_PC_W-1:0] far_target = {pc_p1[11:8], word2}; // RULE_17 RULE_23

  always_comb
  begin
    case (state_r)
      NCE_ST_OPR: state_nxt = NCE_ST_OPA; // RULE_21
      NCE_ST_OPA: state_nxt = NCE_ST_EXE;
      NCE_ST_EXE: state_nxt = two_word ? NCE_ST_OPR2 : (is_src ? NCE_ST_X2 : NCE_ST_OPR);
      NCE_ST_OPR2: state_nxt = NCE_ST_OPA2;
      NCE_ST_OPA2: state_nxt = NCE_ST_OPR;
      NCE_ST_X2: state_nxt = NCE_ST_X3;
      NCE_ST_X3: state_nxt = NCE_ST_OPR;
      default: state_nxt = NCE_ST_OPR;
    endcase
  end

  // Fetch strobes are taken from the next state, so the memory sees phase levels straight from flops.
  wire fetch_upper_nxt = (state_nxt == NCE_ST_OPR) || (state_nxt == NCE_ST_OPR2); // RULE_21
  wire fetch_lower_nxt = (state_nxt == NCE_ST_OPA) || (state_nxt == NCE_ST_OPA2); // RULE_21

  assign acc_nxt = !st_exe ? acc_r :
                   (is_ldm || is_ret) ? operand_nibble : // RULE_02
                   (is_ld || is_xch) ? sel_val : // RULE_03
                   is_add ? sum_add[3:0] :
                   is_sub ? sum_sub[3:0] : acc_r; // RULE_01
  assign carry_link_nxt = (st_exe && is_add) ? sum_add[4] : // RULE_05
                          (st_exe && is_sub) ? sum_sub[4] : carry_link_r; // RULE_06

  // Every fetched word moves the counter by one unless a jump replaces it.
  assign pc_nxt = st_opa ? pc_p1 : // RULE_25
                  (st_exe && is_jin) ? jin_target : // RULE_09
                  (st_exe && is_ret) ? stack_r[0] : // RULE_08
                  st_opa2 ? (jump2 ? far_target : pc_p1) : pc_r; // RULE_19

  wire reg_we = (st_exe && (is_inc || is_xch)) || (st_opa2 && is_isz); // RULE_18
  wire [3:0] reg_wd = is_xch ? accumulator_buffer_r : inc_val;
  wire pair_we = st_opa2 && is_fim; // RULE_20

  // The pair goes out registered so it stands for the whole slot.
  assign bus_nxt.data = (st_exe && is_src) ? even_val : (st_x2 ? odd_val : 4'h0); // RULE_11
  assign bus_nxt.oe = (st_exe && is_src) || st_x2;
  assign bus_nxt.slot_two = st_exe && is_src;
  assign bus_nxt.slot_three = st_x2;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= NCE_ST_OPR;
      opcode_upper_nibble_r <= NCE_NIB_RST;
      operand_nibble_r <= NCE_NIB_RST;
      word2_hi_r <= NCE_NIB_RST;
      acc_r <= NCE_NIB_RST;
      carry_link_r <= 1'b0;
      pc_r <= NCE_PC_RST;
      bus_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (st_opr)
        opcode_upper_nibble_r <= bus_in;
      if (st_opa)
        operand_nibble_r <= bus_in;
      if (st_opr2)
        word2_hi_r <= bus_in;
      acc_r <= acc_nxt;
      carry_link_r <= carry_link_nxt;
      pc_r <= pc_nxt;
      bus_r <= bus_nxt;
    end
  end

  // Reset leaves the upper strobe high, so word zero is fetched on the first edge after release.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_upper_r <= 1'b1;
      fetch_lower_r <= 1'b0;
    end
    else
    begin
      fetch_upper_r <= fetch_upper_nxt;
      fetch_lower_r <= fetch_lower_nxt;
    end
  end

  // The buffer stages the old accumulator one cycle ahead of the swap write.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      accumulator_buffer_r <= NCE_NIB_RST;
    else if (st_opa)
      accumulator_buffer_r <= acc_r; // RULE_04
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        index_r[i] <= NCE_NIB_RST;
    end
    else if (reg_we)
      index_r[operand_nibble] <= reg_wd; // RULE_07
    else if (pair_we)
    begin
      index_r[even_idx] <= word2_hi_r; // RULE_20
      index_r[odd_idx] <= bus_in;
    end
  end

  // A return shifts the three slots down and puts the current counter in the last, so no pointer is needed.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_r[i] <= NCE_PC_RST;
    end
    else if (st_exe && is_ret)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stack_r[i] <= stack_r[i+1]; // RULE_22
      stack_r[STACK_DEPTH-1] <= pc_r;
    end
  end

  assign prog_addr = pc_r;
  assign fetch_upper = fetch_upper_r;
  assign fetch_lower = fetch_lower_r;
  assign bus_o = bus_r;
  assign acc_o = acc_r;
  assign carry_link_o = carry_link_r;

  a_nop_no_change: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    (st_exe && is_nop) |=> (acc_r == $past(acc_r)) && (carry_link_r == $past(carry_link_r))
    && (pc_r == $past(pc_r)) ##1 (state_r == NCE_ST_OPA))
    else $error("No-operation altered state.");

  a_ldm_loads_acc: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    (st_exe && is_ldm) |=> (acc_r == $past(operand_nibble)) && $stable(carry_link_r))
    else $error("Load immediate result wrong.");

  a_ld_copies_reg: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
    (st_exe && is_ld) |=> (acc_r == $past(sel_val)) && $stable(carry_link_r))
    else $error("Load from index result wrong.");

  a_xch_swaps: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
    (st_exe && is_xch) |=> (acc_r == $past(sel_val)) && (index_r[$past(operand_nibble)] == $past(acc_r)))
    else $error("Swap with index result wrong.");

  a_add_carry_out: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
    (st_exe && is_add) |=> ({carry_link_r, acc_r} ==
    {1'b0, $past(acc_r)} + {1'b0, $past(sel_val)} + {4'h0, $past(carry_link_r)}))
    else $error("Add with carry result wrong.");

  a_sub_borrow_out: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
    (st_exe && is_sub && (acc_r < sel_val)) |=> !carry_link_r)
    else $error("Borrow did not clear carry.");

  a_inc_wraps: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
    (st_exe && is_inc && (sel_val == 4'hF)) |=> (index_r[$past(operand_nibble)] == 4'h0) && $stable(carry_link_r))
    else $error("Increment did not wrap.");

  a_ret_pops: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
    (st_exe && is_ret) |=> (pc_r == $past(stack_r[0])) && (acc_r == $past(operand_nibble)))
    else $error("Return did not pop.");

  a_jin_target: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
    (st_exe && is_jin) |=> (pc_r == {$past(pc_r[11:8]), $past(even_val), $past(odd_val)}))
    else $error("Indirect jump target wrong.");

  a_src_slots: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
    (st_exe && is_src) |=> (bus_o.oe && bus_o.slot_two && (bus_o.data == $past(even_val)))
    ##1 (bus_o.oe && bus_o.slot_three && (bus_o.data == $past(odd_val, 2))))
    else $error("Pair not sent in slots.");

  a_two_word_skip: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_25
    (st_opa2 && !jump2) |=> (pc_r == $past(pc_r) + 12'h001))
    else $error("Fall-through did not advance.");

  a_jump_far_page: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_17
    (st_opa2 && jump2 && (pc_r[7:0] == 8'hFF)) |=> (pc_r[11:8] == $past(pc_r[11:8]) + 4'h1))
    else $error("Page-end jump stayed on page.");
endmodule : nce_core

// ### src/nce_pkg.sv
// Purpose: Shared constants and types for the nibble processor execute core.
// Assumes: One system clock; program and data chips share one 4-bit bus.
// Notes: Opcodes are upper-nibble codes; state codes are one-hot.
package nce_pkg;

  localparam int NCE_PC_W = 12;
  localparam int NCE_STACK_DEPTH = 3;

  localparam logic [3:0] NCE_OP_NOP = 4'h0;
  localparam logic [3:0] NCE_OP_JCN = 4'h1;
  localparam logic [3:0] NCE_OP_PAIR_SEND = 4'h2;
  localparam logic [3:0] NCE_OP_PAIR_JUMP = 4'h3;
  localparam logic [3:0] NCE_OP_INC = 4'h6;
  localparam logic [3:0] NCE_OP_ISZ = 4'h7;
  localparam logic [3:0] NCE_OP_ADD = 4'h8;
  localparam logic [3:0] NCE_OP_SUB = 4'h9;
  localparam logic [3:0] NCE_OP_LD = 4'hA;
  localparam logic [3:0] NCE_OP_XCH = 4'hB;
  localparam logic [3:0] NCE_OP_RET = 4'hC;
  localparam logic [3:0] NCE_OP_LDM = 4'hD;

  localparam logic [3:0] NCE_NIB_RST = 4'h0;
  localparam logic [NCE_PC_W-1:0] NCE_PC_RST = 12'h000;

  typedef enum logic [6:0] {
    NCE_ST_OPR = 7'b000_0001,
    NCE_ST_OPA = 7'b000_0010,
    NCE_ST_EXE = 7'b000_0100,
    NCE_ST_OPR2 = 7'b000_1000,
    NCE_ST_OPA2 = 7'b001_0000,
    NCE_ST_X2 = 7'b010_0000,
    NCE_ST_X3 = 7'b100_0000
  } nce_state_t;

  typedef struct packed {
    logic [3:0] data;
    logic oe;
    logic slot_two;
    logic slot_three;
  } nce_bus_t;

endpackage : nce_pkg

// ### src/nce_sync2.sv
// Purpose: Two-stage synchroniser for a level arriving from a pin.
// Assumes: The level changes slowly compared with the clock.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module nce_sync2 (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : nce_sync2

// ### bench/nce_prog_mem.sv
// Purpose: Program memory and data chip address latch on the core's nibble bus.
// Assumes: Memory answers in the same cycle from the fetch address and phase.
// Notes: Outside fetch phases the bus shows the inverse of the last nibble.
`timescale 1ns/10ps
module nce_prog_mem (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [nce_pkg::NCE_PC_W-1:0] prog_addr,
  input wire logic fetch_upper,
  input wire logic fetch_lower,
  input wire nce_pkg::nce_bus_t bus_o,
  output logic [3:0] bus_in,
  output logic [7:0] held_addr
);
  import nce_pkg::*;
  logic [7:0] rom [4096];
  logic [3:0] last_r;
  function automatic void poke(input logic [11:0] a, input logic [7:0] b);
    rom[a] = b;
  endfunction : poke
  function automatic void wipe();
    foreach (rom[i]) rom[i] = 8'h00;
  endfunction : wipe
  // A stale nibble would hide a fetch in the wrong phase, so idle cycles show its inverse.
  assign bus_in = fetch_upper ? rom[prog_addr][7:4] : (fetch_lower ? rom[prog_addr][3:0] : ~last_r);
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      last_r <= 4'h0;
    else if (fetch_upper || fetch_lower)
      last_r <= bus_in;
  // Bits 7:6 pick the chip, 5:4 the register, 3:0 the character; program chips take 7:4.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      held_addr <= 8'h00;
    else if (bus_o.slot_two)
      held_addr[7:4] <= bus_o.data;
    else if (bus_o.slot_three)
      held_addr[3:0] <= bus_o.data;
endmodule : nce_prog_mem

// ### bench/test_nce_core.sv
// Purpose: Self-checking bench for the execute core.
// Assumes: Program memory is filled while the core is held in reset.
// Notes: A reference of the core state predicts every instruction boundary.
`timescale 1ns/10ps
module test_nce_core;
  import nce_pkg::*;
  logic mclk;
  logic rst_n;
  logic test_pin;
  logic [3:0] bus_in;
  logic [NCE_PC_W-1:0] prog_addr;
  logic fetch_upper;
  logic fetch_lower;
  nce_bus_t bus_o;
  logic [3:0] acc_o;
  logic carry_link_o;
  logic fu_q;
  logic skip_q;
  logic [17:0] cur_note;
  logic [7:0] held;
  logic [7:0] held_exp;
  int bad_count;
  int comparisons;
  logic [17:0] nq[$];
  logic [3:0] bq[$];
  logic [11:0] pc;
  logic [3:0] acc;
  logic [3:0] r[16];
  logic cy;
  logic tp;
  logic [3:0] ops[5] = '{NCE_OP_LD, NCE_OP_XCH, NCE_OP_ADD, NCE_OP_SUB, NCE_OP_INC};
  nce_core dut (.mclk(mclk), .rst_n(rst_n), .bus_in(bus_in), .test_pin(test_pin), .prog_addr(prog_addr),
    .fetch_upper(fetch_upper), .fetch_lower(fetch_lower), .bus_o(bus_o), .acc_o(acc_o), .carry_link_o(carry_link_o));
  nce_prog_mem pm (.mclk(mclk), .rst_n(rst_n), .prog_addr(prog_addr), .fetch_upper(fetch_upper),
    .fetch_lower(fetch_lower), .bus_o(bus_o), .bus_in(bus_in), .held_addr(held));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // Results of an instruction are judged when the next opcode fetch begins.
  // The second-word fetch of a two-word instruction also raises the upper strobe, so it is skipped.
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      fu_q <= 1'b1;
      skip_q <= 1'b0;
    end
    else
    begin
      if (fetch_upper && !fu_q && nq.size() > 0)
      begin
        if (skip_q)
          skip_q <= 1'b0;
        else
        begin
          cur_note = nq.pop_front();
          chk("state", cur_note[16:0], {prog_addr, acc_o, carry_link_o});
          skip_q <= (nq.size() > 0) && nq[0][17];
        end
      end
      if ((bus_o.slot_two || bus_o.slot_three) && bq.size() > 0)
        chk("bus", {12'h000, 1'b1, bq.pop_front()}, {12'h000, bus_o.oe, bus_o.data});
      else
        chk("bus idle", 17'h0_0000, {12'h000, bus_o.oe, bus_o.data});
      fu_q <= fetch_upper;
    end
  // Places one instruction in memory and steps the reference through it.
  task automatic ins(input logic [3:0] op, input logic [3:0] a, input logic [7:0] b2);
    logic [4:0] s;
    logic [3:0] t;
    logic j;
    logic w;
    pm.poke(pc, {op, a});
    pc = pc + 12'h001;
    w = (op == NCE_OP_JCN) || (op == NCE_OP_ISZ) || ((op == NCE_OP_PAIR_SEND) && !a[0]);
    if (w)
    begin
      pm.poke(pc, b2);
      pc = pc + 12'h001;
    end
    j = 1'b0;
    case (op)
      NCE_OP_LDM: acc = a;
      NCE_OP_LD: acc = r[a];
      NCE_OP_XCH:
      begin
        t = acc;
        acc = r[a];
        r[a] = t;
      end
      NCE_OP_ADD:
      begin
        s = {1'b0, acc} + {1'b0, r[a]} + {4'h0, cy};
        {cy, acc} = s;
      end
      NCE_OP_SUB:
      begin
        s = {1'b0, acc} + {1'b0, ~r[a]} + {4'h0, ~cy};
        {cy, acc} = s;
      end
      NCE_OP_INC: r[a] = r[a] + 4'h1;
      NCE_OP_RET:
      begin
        acc = a;
        pc = NCE_PC_RST;
      end
      NCE_OP_PAIR_JUMP:
        if (a[0])
          pc = {pc[11:8], r[{a[3:1], 1'b0}], r[a]};
      NCE_OP_PAIR_SEND:
        if (a[0])
        begin
          bq.push_back(r[{a[3:1], 1'b0}]);
          bq.push_back(r[a]);
          held_exp = {r[{a[3:1], 1'b0}], r[a]};
        end
        else
          {r[a], r[a | 4'h1]} = b2;
      NCE_OP_JCN: j = (a[2] && acc == 4'h0) || (a[1] && cy) || (a[0] && (a[3] ? tp : !tp));
      NCE_OP_ISZ:
      begin
        r[a] = r[a] + 4'h1;
        j = (r[a] != 4'h0);
      end
      default: ;
    endcase
    // The page comes from the address after the last fetched word.
    if (j)
      pc = {pc[11:8], b2};
    nq.push_back({w, pc, acc, cy});
  endtask : ins
  task automatic pad(input logic [11:0] upto);
    while (pc != upto) ins(NCE_OP_NOP, 4'h0, 8'h00);
  endtask : pad
  task automatic run_prog(input logic t);
    tp = t;
    pm.wipe();
    pc = 12'h000;
    acc = 4'h0;
    cy = 1'b0;
    held_exp = 8'h00;
    foreach (r[i]) r[i] = 4'h0;
    ins(NCE_OP_NOP, 4'h0, 8'h00);
    for (int p = 0; p < 8; p++) ins(NCE_OP_PAIR_SEND, 4'(2 * p), 8'($urandom));
    ins(NCE_OP_LDM, 4'($urandom), 8'h00);
    for (int i = 0; i < 24; i++) ins(ops[$urandom % 5], 4'($urandom), 8'h00);
    ins(NCE_OP_PAIR_SEND, 4'($urandom) | 4'h1, 8'h00);
    ins(NCE_OP_PAIR_SEND, 4'h6, pc[7:0] + 8'h05);
    ins(NCE_OP_PAIR_JUMP, 4'h7, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      ins(NCE_OP_LDM, ($urandom % 2) ? 4'h0 : 4'($urandom), 8'h00);
      ins(NCE_OP_ADD, 4'($urandom), 8'h00);
      ins(NCE_OP_JCN, 4'(c), pc[7:0] + 8'h03);
    end
    for (int k = 0; k < 4; k++) ins(NCE_OP_ISZ, 4'($urandom), pc[7:0] + 8'h03);
    ins(NCE_OP_LDM, 4'hF, 8'h00);
    ins(NCE_OP_XCH, 4'h5, 8'h00);
    ins(NCE_OP_ISZ, 4'h5, pc[7:0] + 8'h03);
    ins(NCE_OP_LDM, 4'h0, 8'h00);
    pad(12'h1FE);
    ins(NCE_OP_JCN, 4'h4, 8'h10);
    ins(NCE_OP_LDM, 4'h3, 8'h00);
    ins(NCE_OP_XCH, 4'h9, 8'h00);
    pad(12'h2FE);
    ins(NCE_OP_ISZ, 4'h9, 8'h20);
    ins(NCE_OP_PAIR_SEND, 4'h4, 8'h40);
    pad(12'h3FF);
    ins(NCE_OP_PAIR_JUMP, 4'h5, 8'h00);
    ins(NCE_OP_RET, 4'($urandom), 8'h00);
  endtask : run_prog
  initial
  begin
    rst_n = 1'b0;
    test_pin = 1'b0;
    void'($urandom(46));
    for (int run = 0; run < 2; run++)
    begin
      test_pin <= run[0];
      run_prog(run[0]);
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      for (int k = 0; k < 20000 && (nq.size() > 0 || bq.size() > 0); k++) @(posedge mclk);
      if (nq.size() > 0 || bq.size() > 0)
      begin
        bad_count++;
        finish_test();
      end
      chk("held", {9'h000, held_exp}, {9'h000, held});
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
    end
    finish_test();
  end
endmodule : test_nce_core
